// ### hasu_map.svh
// Purpose: Constants for the hex/text conversion and single-bit shift unit
// Assumes: 16-bit controller register words
// Notes:   Included by the package and the unit itself
`ifndef HASU_MAP_SVH
`define HASU_MAP_SVH

// Word, address and table size widths
`define HASU_WORD_W       16
`define HASU_ADDR_W       16
`define HASU_SIZE_W       7

// Allowed table sizes
`define HASU_TO_TEXT_MAX  7'h20
`define HASU_TO_HEX_MAX   7'h40
`define HASU_IDX_SIZE     7'h01

// Character codes accepted as hex digits, and digit conversion constants
`define HASU_CHR_0        8'h30
`define HASU_CHR_9        8'h39
`define HASU_CHR_A        8'h41
`define HASU_CHR_F        8'h46
`define HASU_CHR_BIAS     4'h9
`define HASU_DIGIT_TEN    4'hA

// Reset values of the flags and result
`define HASU_FLAG_RST     1'b0
`define HASU_RESULT_RST   16'h0000

`endif

// ### hasu_pkg.sv
// Purpose: Types shared by the hex/text conversion and shift unit
// Assumes: hasu_map.svh is on the include path
// Notes:   Request and memory port travel as packed structs
`default_nettype none
`include "hasu_map.svh"

package hasu_pkg;

    typedef enum logic [2:0] {
        HASU_TEST,
        HASU_RSHIFT,
        HASU_LSHIFT,
        HASU_TO_TEXT,
        HASU_TO_HEX
    } hasu_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VRD,
        ST_VWT,
        ST_VCHK,
        ST_RD,
        ST_WT,
        ST_GET,
        ST_WR2
    } hasu_state_t;

    // One instruction as issued by the scan sequencer
    typedef struct packed {
        hasu_op_t                  op;
        logic                      cond;
        logic                      src_indexed;
        logic [`HASU_SIZE_W-1:0]   size;
        logic [`HASU_ADDR_W-1:0]   src_addr;
        logic [`HASU_ADDR_W-1:0]   dst_addr;
        logic [`HASU_WORD_W-1:0]   word_a;
        logic [`HASU_WORD_W-1:0]   word_b;
    } hasu_req_t;

    // Request toward the register memory
    typedef struct packed {
        logic                      rd;
        logic                      wr;
        logic [`HASU_ADDR_W-1:0]   addr;
        logic [`HASU_WORD_W-1:0]   wdata;
    } hasu_mem_t;

endpackage : hasu_pkg
`default_nettype wire

// ### hasu_unit.sv
// Purpose: Executes bit test, single-bit shifts and hex/text table conversion
// Assumes: Register memory answers a read one cycle after it sees o_mem.rd
// Notes:   One instruction at a time; i_start is ignored while busy
`timescale 1ns/1ps
`default_nettype none
`include "hasu_map.svh"

module hasu_unit
    import hasu_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    // Instruction issue
    input  wire logic                    i_start,
    input  wire hasu_req_t               i_req,
    input  wire logic                    i_err_clr,
    // Instruction status
    output logic                         o_busy,
    output logic                         o_done,
    output logic                         o_out,
    output logic [`HASU_WORD_W-1:0]      o_result,
    // Flags
    output logic                         o_carry_flag,
    output logic                         o_operation_error_flag,
    output logic                         o_boundary_error_flag,
    // Register memory
    output var hasu_mem_t                o_mem,
    input  wire logic [`HASU_WORD_W-1:0] i_mem_rdata
);

    function automatic logic [7:0] nib_to_text(input logic [3:0] nib);
        if (nib < `HASU_DIGIT_TEN) begin
            return `HASU_CHR_0 + {4'h0, nib};
        end
        return `HASU_CHR_A + {4'h0, nib - `HASU_DIGIT_TEN};
    endfunction : nib_to_text

    function automatic logic [3:0] text_to_nib(input logic [7:0] chr);
        if (chr <= `HASU_CHR_9) begin
            return chr[3:0];
        end
        return chr[3:0] + `HASU_CHR_BIAS;
    endfunction : text_to_nib

    function automatic logic text_ok(input logic [7:0] chr);
        return ((chr >= `HASU_CHR_0) && (chr <= `HASU_CHR_9)) ||
               ((chr >= `HASU_CHR_A) && (chr <= `HASU_CHR_F));
    endfunction : text_ok

    function automatic logic [`HASU_ADDR_W-1:0] adr_add(
        input logic [`HASU_ADDR_W-1:0] base,
        input logic [`HASU_SIZE_W-1:0] off);
        return base + {{(`HASU_ADDR_W-`HASU_SIZE_W){1'b0}}, off};
    endfunction : adr_add

    hasu_state_t               st_q,     st_d;
    hasu_req_t                 req_q,    req_d;
    hasu_mem_t                 mem_q,    mem_d;
    logic [`HASU_SIZE_W-1:0]   k_q,      k_d;
    logic [`HASU_WORD_W-1:0]   word_q,   word_d;
    logic [7:0]                acc_q,    acc_d;
    logic [`HASU_WORD_W-1:0]   res_q,    res_d;
    logic                      out_q,    out_d;
    logic                      carry_q,  carry_d;
    logic                      err_q,    err_d;
    logic                      bnd_q,    bnd_d;
    logic                      done_q,   done_d;
    logic                      err_set;
    logic                      bnd_set;

    // Decoding of the issued instruction
    wire logic                    idle      = (st_q == ST_IDLE);
    wire logic                    take      = i_start && idle;
    wire logic [`HASU_SIZE_W-1:0] size_max  = (i_req.op == HASU_TO_TEXT) ? `HASU_TO_TEXT_MAX
                                                                         : `HASU_TO_HEX_MAX;
    wire logic                    bad_size  = (i_req.size == '0) ||
                                              (i_req.size > size_max) ||
                                              (i_req.src_indexed &&
                                               (i_req.size != `HASU_IDX_SIZE));
    wire logic                    last      = (k_q == req_q.size - `HASU_IDX_SIZE);
    wire logic                    chars_ok  = text_ok(i_mem_rdata[7:0]) &&
                                              text_ok(i_mem_rdata[15:8]);
    wire logic [`HASU_WORD_W-1:0] shr_val   = {1'b0, i_req.word_a[15:1]};
    wire logic [`HASU_WORD_W-1:0] shl_val   = {i_req.word_a[14:0], 1'b0};
    wire logic [`HASU_SIZE_W-1:0] k_twice   = {k_q[`HASU_SIZE_W-2:0], 1'b0};
    wire logic [`HASU_SIZE_W-1:0] k_half    = {1'b0, k_q[`HASU_SIZE_W-1:1]};
    wire logic [7:0]              pair_nibs = {text_to_nib(i_mem_rdata[7:0]),
                                               text_to_nib(i_mem_rdata[15:8])};

    always_comb begin
        st_d    = st_q;
        req_d   = req_q;
        mem_d   = '0;
        k_d     = k_q;
        word_d  = word_q;
        acc_d   = acc_q;
        res_d   = res_q;
        out_d   = out_q;
        carry_d = carry_q;
        done_d  = 1'b0;
        err_set = 1'b0;
        bnd_set = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (take) begin
                    req_d = i_req;
                    k_d   = '0;
                    if (!i_req.cond) begin
                        out_d  = 1'b0;
                        done_d = 1'b1;
                    end else begin
                        case (i_req.op)
                            HASU_TEST: begin
                                out_d  = |(i_req.word_a & i_req.word_b);
                                done_d = 1'b1;
                            end
                            HASU_RSHIFT: begin
                                res_d   = shr_val;
                                carry_d = i_req.word_a[0];
                                out_d   = shr_val[0];
                                done_d  = 1'b1;
                            end
                            HASU_LSHIFT: begin
                                res_d   = shl_val;
                                carry_d = i_req.word_a[15];
                                out_d   = shl_val[15];
                                done_d  = 1'b1;
                            end
                            HASU_TO_TEXT, HASU_TO_HEX: begin
                                if (bad_size) begin
                                    bnd_set = 1'b1;
                                    out_d   = 1'b0;
                                    done_d  = 1'b1;
                                end else begin
                                    out_d = 1'b0;
                                    st_d  = (i_req.op == HASU_TO_HEX) ? ST_VRD : ST_RD;
                                end
                            end
                            default: begin
                                out_d  = 1'b0;
                                done_d = 1'b1;
                            end
                        endcase
                    end
                end
            end
            // Whole table checked before any write, so a bad code leaves memory untouched
            ST_VRD: begin
                mem_d.rd   = 1'b1;
                mem_d.addr = adr_add(req_q.src_addr, k_q);
                st_d       = ST_VWT;
            end
            ST_VWT: begin
                st_d = ST_VCHK;
            end
            ST_VCHK: begin
                if (!chars_ok) begin
                    err_set = 1'b1;
                    out_d   = 1'b0;
                    done_d  = 1'b1;
                    st_d    = ST_IDLE;
                end else if (last) begin
                    k_d  = '0;
                    st_d = ST_RD;
                end else begin
                    k_d  = k_q + `HASU_IDX_SIZE;
                    st_d = ST_VRD;
                end
            end
            ST_RD: begin
                mem_d.rd   = 1'b1;
                mem_d.addr = adr_add(req_q.src_addr, k_q);
                st_d       = ST_WT;
            end
            ST_WT: begin
                st_d = ST_GET;
            end
            ST_GET: begin
                if (req_q.op == HASU_TO_TEXT) begin
                    word_d      = i_mem_rdata;
                    mem_d.wr    = 1'b1;
                    mem_d.addr  = adr_add(req_q.dst_addr, k_twice);
                    mem_d.wdata = {nib_to_text(i_mem_rdata[11:8]),
                                   nib_to_text(i_mem_rdata[15:12])};
                    st_d        = ST_WR2;
                end else if (!k_q[0]) begin
                    acc_d = pair_nibs;
                    if (last) begin
                        // Odd size: lower two digits have no source, left as zero
                        mem_d.wr    = 1'b1;
                        mem_d.addr  = adr_add(req_q.dst_addr, k_half);
                        mem_d.wdata = {pair_nibs, 8'h00};
                        out_d       = 1'b1;
                        done_d      = 1'b1;
                        st_d        = ST_IDLE;
                    end else begin
                        k_d  = k_q + `HASU_IDX_SIZE;
                        st_d = ST_RD;
                    end
                end else begin
                    mem_d.wr    = 1'b1;
                    mem_d.addr  = adr_add(req_q.dst_addr, k_half);
                    mem_d.wdata = {acc_q, pair_nibs};
                    if (last) begin
                        out_d  = 1'b1;
                        done_d = 1'b1;
                        st_d   = ST_IDLE;
                    end else begin
                        k_d  = k_q + `HASU_IDX_SIZE;
                        st_d = ST_RD;
                    end
                end
            end
            ST_WR2: begin
                mem_d.wr    = 1'b1;
                mem_d.addr  = adr_add(req_q.dst_addr, k_twice + `HASU_IDX_SIZE);
                mem_d.wdata = {nib_to_text(word_q[3:0]), nib_to_text(word_q[7:4])};
                if (last) begin
                    out_d  = 1'b1;
                    done_d = 1'b1;
                    st_d   = ST_IDLE;
                end else begin
                    k_d  = k_q + `HASU_IDX_SIZE;
                    st_d = ST_RD;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // A new error outranks a clear in the same cycle
        err_d = err_set | (err_q & ~i_err_clr);
        bnd_d = bnd_set | (bnd_q & ~i_err_clr);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q    <= ST_IDLE;
            req_q   <= '0;
            mem_q   <= '0;
            k_q     <= '0;
            word_q  <= '0;
            acc_q   <= '0;
            res_q   <= `HASU_RESULT_RST;
            out_q   <= `HASU_FLAG_RST;
            carry_q <= `HASU_FLAG_RST;
            err_q   <= `HASU_FLAG_RST;
            bnd_q   <= `HASU_FLAG_RST;
            done_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            req_q   <= req_d;
            mem_q   <= mem_d;
            k_q     <= k_d;
            word_q  <= word_d;
            acc_q   <= acc_d;
            res_q   <= res_d;
            out_q   <= out_d;
            carry_q <= carry_d;
            err_q   <= err_d;
            bnd_q   <= bnd_d;
            done_q  <= done_d;
        end
    end

    assign o_busy                 = !idle;
    assign o_done                 = done_q;
    assign o_out                  = out_q;
    assign o_result               = res_q;
    assign o_carry_flag           = carry_q;
    assign o_operation_error_flag = err_q;
    assign o_boundary_error_flag  = bnd_q;
    assign o_mem                  = mem_q;

    // Checks
    property p_test;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_TEST
        |=> o_done && (o_out == |($past(i_req.word_a) & $past(i_req.word_b)));
    endproperty
    a_test: assert property (p_test) else $error("bit test output wrong");

    property p_shr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_RSHIFT
        |=> o_result == ($past(i_req.word_a) >> 1) && o_carry_flag == $past(i_req.word_a[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("right shift result or carry wrong");

    property p_shr_out;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_RSHIFT |=> o_out == o_result[0];
    endproperty
    a_shr_out: assert property (p_shr_out) else $error("right shift output wrong");

    property p_shl;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_LSHIFT
        |=> o_result == ($past(i_req.word_a) << 1) && o_carry_flag == $past(i_req.word_a[15]);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift result or carry wrong");

    property p_shl_out;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_LSHIFT |=> o_out == o_result[15];
    endproperty
    a_shl_out: assert property (p_shl_out) else $error("left shift output wrong");

    property p_off;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && !i_req.cond && !i_err_clr
        |=> o_done && !o_out && $stable(o_carry_flag) && $stable(o_operation_error_flag);
    endproperty
    a_off: assert property (p_off) else $error("disabled instruction changed state");

    property p_bound;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && (i_req.op == HASU_TO_TEXT || i_req.op == HASU_TO_HEX) &&
        i_req.src_indexed && i_req.size > `HASU_IDX_SIZE
        |=> o_boundary_error_flag && o_done && !o_out && !o_busy;
    endproperty
    a_bound: assert property (p_bound) else $error("indexed table size not refused");

    property p_text_msd;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_mem.wr && req_q.op == HASU_TO_TEXT && st_q == ST_WR2
        |-> o_mem.wdata[7:0] == nib_to_text(word_q[15:12]) &&
            o_mem.wdata[15:8] == nib_to_text(word_q[11:8]);
    endproperty
    a_text_msd: assert property (p_text_msd) else $error("hex to text digit order wrong");

    property p_bad_char;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q == ST_VCHK && !chars_ok
        |=> o_operation_error_flag && !o_out && o_done ##1 !o_mem.wr;
    endproperty
    a_bad_char: assert property (p_bad_char) else $error("bad character not flagged");

    property p_no_early_write;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ST_VWT || st_q == ST_VCHK || st_q == ST_VRD) |-> !o_mem.wr;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write during check");

    c_text_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_done && o_out && req_q.op == HASU_TO_TEXT);
    c_hex_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_done && o_out && req_q.op == HASU_TO_HEX);
    c_hex_err: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q == ST_VCHK && !chars_ok);
    c_shr_carry: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        take && i_req.cond && i_req.op == HASU_RSHIFT && i_req.word_a[0]);

endmodule : hasu_unit
`default_nettype wire

// ### tb_hasu_unit.sv
// Purpose: Self-checking bench for the hex/text conversion and shift unit
// Assumes: Memory model answers one cycle after a read strobe; tables live below 256
// Notes:   Driver queues expected status; monitor compares it when o_done pulses
`timescale 1ns/1ps
`default_nettype none
`include "hasu_map.svh"

module tb_hasu_unit
    import hasu_pkg::*;
;
    typedef struct packed {
        logic        out;
        logic        carry;
        logic        oerr;
        logic        berr;
        logic [15:0] res;
    } hasu_note_t;

    logic        i_clk_sys;
    logic        i_rst_n;
    logic        i_start;
    hasu_req_t   i_req;
    logic        i_err_clr;
    logic        o_busy;
    logic        o_done;
    logic        o_out;
    logic [15:0] o_result;
    logic        o_carry_flag;
    logic        o_operation_error_flag;
    logic        o_boundary_error_flag;
    hasu_mem_t   o_mem;
    logic [15:0] i_mem_rdata = 16'h0000;
    logic [15:0] mem [256];
    logic [15:0] exp_mem [256];
    logic        hold_q = 1'b0;
    hasu_note_t  notes [$];
    hasu_note_t  nt;
    logic [15:0] exp_res = 16'h0000;
    logic        exp_carry = 1'b0;
    logic        exp_oerr = 1'b0;
    logic        exp_berr = 1'b0;
    int          fail_count = 0;
    int          compares = 0;
    logic [7:0]  bad_chr [5] = '{8'h2F, 8'h3A, 8'h40, 8'h47, 8'h61};
    logic [15:0] edge_w [6] = '{16'h0000, 16'h0001, 16'h8000, 16'h8001, 16'hFFFF, 16'h7FFE};

    hasu_unit dut_u (
        .i_clk_sys              (i_clk_sys),
        .i_rst_n                (i_rst_n),
        .i_start                (i_start),
        .i_req                  (i_req),
        .i_err_clr              (i_err_clr),
        .o_busy                 (o_busy),
        .o_done                 (o_done),
        .o_out                  (o_out),
        .o_result               (o_result),
        .o_carry_flag           (o_carry_flag),
        .o_operation_error_flag (o_operation_error_flag),
        .o_boundary_error_flag  (o_boundary_error_flag),
        .o_mem                  (o_mem),
        .i_mem_rdata            (i_mem_rdata)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // Read data stays one extra cycle, then inverts every cycle so stale data mismatches on alternate cycles
    always @(posedge i_clk_sys) if (o_mem.wr === 1'b1) mem[o_mem.addr[7:0]] <= o_mem.wdata;
    always @(negedge i_clk_sys) begin
        if (o_mem.rd === 1'b1) begin
            i_mem_rdata <= mem[o_mem.addr[7:0]];
            hold_q      <= 1'b1;
        end else if (hold_q) hold_q <= 1'b0;
        else i_mem_rdata <= ~i_mem_rdata;
    end

    function automatic logic [7:0] hc(input logic [3:0] d);
        return (d < 4'hA) ? {4'h3, d} : 8'h37 + {4'h0, d};
    endfunction : hc

    function automatic logic ok_chr(input logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction : ok_chr

    function automatic logic [3:0] hv(input logic [7:0] c);
        return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
    endfunction : hv

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    always @(negedge i_clk_sys) begin
        if (i_rst_n && o_done === 1'b1) begin
            if (notes.size() == 0) check(16'h0001, 16'h0000);
            else begin
                nt = notes.pop_front();
                check({15'h0, o_out}, {15'h0, nt.out});
                check({15'h0, o_carry_flag}, {15'h0, nt.carry});
                check({15'h0, o_operation_error_flag}, {15'h0, nt.oerr});
                check({15'h0, o_boundary_error_flag}, {15'h0, nt.berr});
                check(o_result, nt.res);
            end
        end
    end

    task automatic poke(input int a, input logic [15:0] v);
        mem[a]     = v;
        exp_mem[a] = v;
    endtask : poke

    task automatic fill(input int n, input logic text);
        for (int k = 0; k < n; k++) begin
            if (text) poke(k, {hc(4'($urandom)), hc(4'($urandom))});
            else poke(k, 16'($urandom));
        end
    endtask : fill

    task automatic clr_err();
        i_err_clr = 1'b1;
        @(negedge i_clk_sys);
        i_err_clr = 1'b0;
        exp_oerr  = 1'b0;
        exp_berr  = 1'b0;
    endtask : clr_err

    task automatic run(input hasu_op_t op, input logic cond, input logic idx,
                       input logic [6:0] n, input logic [15:0] a, input logic [15:0] b);
        hasu_note_t  e;
        logic        bad;
        logic [15:0] s0;
        logic [15:0] s1;
        int          i;
        logic        eb;
        e.out = 1'b0;
        eb    = 1'b0;
        if (cond) begin
            case (op)
                HASU_TEST: e.out = |(a & b);
                HASU_RSHIFT: begin
                    exp_res   = {1'b0, a[15:1]};
                    exp_carry = a[0];
                    e.out     = exp_res[0];
                end
                HASU_LSHIFT: begin
                    exp_res   = {a[14:0], 1'b0};
                    exp_carry = a[15];
                    e.out     = exp_res[15];
                end
                HASU_TO_TEXT: begin
                    if (n == 0 || n > 32 || (idx && n != 1)) exp_berr = 1'b1;
                    else begin
                        e.out = 1'b1;
                        eb    = 1'b1;
                        for (int k = 0; k < n; k++) begin
                            s0 = mem[k];
                            exp_mem[128 + 2 * k] = {hc(s0[11:8]), hc(s0[15:12])};
                            exp_mem[129 + 2 * k] = {hc(s0[3:0]), hc(s0[7:4])};
                        end
                    end
                end
                default: begin
                    bad = 1'b0;
                    for (int k = 0; k < n; k++) begin
                        bad |= !ok_chr(mem[k][7:0]) || !ok_chr(mem[k][15:8]);
                    end
                    if (n == 0 || n > 64 || (idx && n != 1)) exp_berr = 1'b1;
                    else eb = 1'b1;
                    if (!eb) e.out = 1'b0;
                    else if (bad) exp_oerr = 1'b1;
                    else begin
                        e.out = 1'b1;
                        for (int j = 0; 2 * j < n; j++) begin
                            s0 = mem[2 * j];
                            s1 = mem[2 * j + 1];
                            exp_mem[128 + j] = {hv(s0[7:0]), hv(s0[15:8]),
                                (2 * j + 1 < n) ? {hv(s1[7:0]), hv(s1[15:8])} : 8'h00};
                        end
                    end
                end
            endcase
        end
        e.carry = exp_carry;
        e.oerr  = exp_oerr;
        e.berr  = exp_berr;
        e.res   = exp_res;
        notes.push_back(e);
        i_req   = '{op: op, cond: cond, src_indexed: idx, size: n, src_addr: 16'h0000,
                    dst_addr: 16'h0080, word_a: a, word_b: b};
        i_start = 1'b1;
        @(negedge i_clk_sys);
        i_start = 1'b0;
        check({15'h0, o_busy}, {15'h0, eb});
        for (i = 0; i < 1000 && o_done !== 1'b1; i++) @(negedge i_clk_sys);
        if (i == 1000) begin
            fail_count++;
            finish_test();
        end
        @(negedge i_clk_sys);
        for (int k = 0; k < 256; k++) check(mem[k], exp_mem[k]);
    endtask : run

    initial begin
        i_rst_n   = 1'b0;
        i_start   = 1'b0;
        i_req     = '0;
        i_err_clr = 1'b0;
        void'($urandom(23));
        for (int k = 0; k < 256; k++) poke(k, 16'($urandom));
        repeat (6) @(negedge i_clk_sys);
        check({o_busy, o_done, o_out, o_carry_flag, o_operation_error_flag,
               o_boundary_error_flag, o_result[9:0]}, 16'h0000);
        i_rst_n = 1'b1;
        @(negedge i_clk_sys);
        fill(4, 1'b1);
        poke(0, 16'h3930);
        poke(1, 16'h4641);
        run(HASU_TO_HEX, 1'b1, 1'b0, 7'h04, 16'h0000, 16'h0000);
        for (int m = 0; m < 5; m++) begin
            fill(6, 1'b1);
            poke(m, m[0] ? {bad_chr[m], 8'h30} : {8'h41, bad_chr[m]});
            run(HASU_TO_HEX, 1'b1, 1'b0, 7'h06, 16'h0000, 16'h0000);
            run(HASU_TO_HEX, 1'b0, 1'b0, 7'h06, 16'h0000, 16'h0000);
            clr_err();
        end
        fill(64, 1'b1);
        run(HASU_TO_HEX, 1'b1, 1'b0, 7'h40, 16'h0000, 16'h0000);
        run(HASU_TO_HEX, 1'b1, 1'b0, 7'h03, 16'h0000, 16'h0000);
        run(HASU_TO_HEX, 1'b1, 1'b1, 7'h01, 16'h0000, 16'h0000);
        run(HASU_TO_HEX, 1'b1, 1'b1, 7'h02, 16'h0000, 16'h0000);
        clr_err();
        run(HASU_TO_HEX, 1'b1, 1'b0, 7'h41, 16'h0000, 16'h0000);
        clr_err();
        run(HASU_TO_HEX, 1'b1, 1'b0, 7'h00, 16'h0000, 16'h0000);
        clr_err();
        fill(32, 1'b0);
        run(HASU_TO_TEXT, 1'b1, 1'b0, 7'h01, 16'h0000, 16'h0000);
        run(HASU_TO_TEXT, 1'b1, 1'b0, 7'h20, 16'h0000, 16'h0000);
        run(HASU_TO_TEXT, 1'b0, 1'b0, 7'h28, 16'h0000, 16'h0000);
        run(HASU_TO_TEXT, 1'b1, 1'b0, 7'h21, 16'h0000, 16'h0000);
        clr_err();
        run(HASU_TO_TEXT, 1'b1, 1'b1, 7'h02, 16'h0000, 16'h0000);
        clr_err();
        run(HASU_TO_TEXT, 1'b1, 1'b1, 7'h01, 16'h0000, 16'h0000);
        for (int m = 0; m < 36; m++) begin
            logic [15:0] w;
            logic        c;
            w = (m < 6) ? edge_w[m] : 16'($urandom);
            c = (m < 6) || ($urandom % 4 != 0);
            run(HASU_RSHIFT, c, 1'b0, 7'h01, w, 16'h0000);
            run(HASU_RSHIFT, c, 1'b0, 7'h01, w, 16'h0000);
            run(HASU_LSHIFT, c, 1'b0, 7'h01, w, 16'h0000);
            run(HASU_TEST, c, 1'b0, 7'h01, w, (m % 3 == 0) ? ~w : 16'($urandom));
        end
        finish_test();
    end
endmodule : tb_hasu_unit
`default_nettype wire
